// ---- rtl/dram_refresh_postpone_ctrl.sv ----
// refresh postponement control with clock-ratio rescaling, APB registers
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
// How it works
// (R1) rescale window counters on clock switch
// (R2) postponed count never passes urgent level
// (R3) dyn_freq_switch_en low blocks frequency changes
// (R4) software sets thresholds before starting init
// (R5) thresholds frozen once initialization starts
// (R6) software picks smallest threshold over transitions
// (R7) ratio>=7 per-bank: levels 19, 18, cap 8
// (R8) ratio>=7 all-bank: urgent 17, cap 8
// (R9) ratio<7: urgent 21, normal below, cap 8
// (R10) urgent refresh burst, capped per interval
module dram_refresh_postpone_ctrl
   import refresh_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   // command scheduler side
   output logic                   ref_req,
   output logic                   ref_urgent,
   output logic                   per_bank_refresh_en,
   output logic                   bank_refresh_more,
   input  wire logic              ref_done,
   // clock switching side
   output logic                   freq_change_req,
   output logic [DIV_W-1:0]       freq_div,
   input  wire logic              freq_change_ack,
   output logic                   ctrl_initialized
);
   // ------------------------------------------------------------
   // register state
   // ------------------------------------------------------------
   logic                 dyn_freq_switch_en_ff;
   logic                 pbr_ff;
   logic                 init_ff;
   logic [LVL_W-1:0]     urgent_lvl_ff;
   logic [LVL_W-1:0]     normal_lvl_ff;
   logic [LVL_W-1:0]     cap_ff;
   logic [LVL_W-1:0]     bank_lvl_ff;
   logic [DIV_W-1:0]     div_ff;
   logic [DIV_W-1:0]     target_div_ff;
   logic [31:0]          prdata_ff;
   logic                 pslverr_ff;

   // ------------------------------------------------------------
   // refresh accounting state
   // ------------------------------------------------------------
   logic [LVL_W-1:0]     postponed_ff;
   logic [LVL_W-1:0]     burst_ff;
   logic                 urgent_ff;
   logic [TMR_W-1:0]     period_ff;
   logic [TMR_W-1:0]     rem_scaled_ff;
   sw_state_t            sw_ff;
   sw_state_t            nxt_sw;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   wire access    = psel && penable;
   wire wr        = access && pwrite;
   wire hit_ctrl  = (paddr == OFS_CTRL);
   wire hit_th    = (paddr == OFS_THRESH);
   wire hit_freq  = (paddr == OFS_FREQ);
   wire hit_st    = (paddr == OFS_STATUS);
   wire mapped    = hit_ctrl || hit_th || hit_freq || hit_st;
   wire wr_ctrl   = wr && hit_ctrl;
   wire wr_th     = wr && hit_th && !init_ff;                      // [R5]
   wire wr_freq   = wr && hit_freq;
   wire sw_idle   = (sw_ff == SW_IDLE);
   wire [DIV_W-1:0] req_div = pwdata[DIV_W-1:0];
   wire switch_go = wr_freq && init_ff && dyn_freq_switch_en_ff    // [R3]
                    && sw_idle && (req_div != '0) && (req_div != div_ff);

   function automatic logic [LVL_W-1:0] fld(input logic [31:0] d, input int lsb);
      fld = d[lsb +: LVL_W];
   endfunction

   wire [31:0] rd_ctrl = 32'({init_ff, pbr_ff, dyn_freq_switch_en_ff});
   wire [31:0] rd_th   = (32'(bank_lvl_ff) << TH_BNK_LSB) | (32'(cap_ff) << TH_CAP_LSB)
                       | (32'(normal_lvl_ff) << TH_NRM_LSB) | (32'(urgent_lvl_ff) << TH_URG_LSB);
   wire [31:0] rd_st   = (32'(div_ff) << ST_DIV_LSB) | (32'(postponed_ff) << ST_CNT_LSB)
                       | (32'(urgent_ff) << ST_URG) | (32'(!sw_idle) << ST_BUSY)
                       | (32'(init_ff) << ST_INIT);
   wire [31:0] rd_mux  = hit_ctrl ? rd_ctrl :
                         hit_th   ? rd_th   :
                         hit_freq ? 32'(target_div_ff) :
                         hit_st   ? rd_st   : 32'h0000_0000;

   assign pready  = 1'b1;
   assign prdata  = prdata_ff;
   assign pslverr = pslverr_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else begin
         prdata_ff  <= (psel && !penable && !pwrite) ? rd_mux : prdata_ff;
         pslverr_ff <= psel && !penable && !mapped;
      end
   end

   // ------------------------------------------------------------
   // control and threshold registers
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         dyn_freq_switch_en_ff <= 1'b0;
         pbr_ff                <= 1'b0;
         init_ff               <= 1'b0;
      end else if (wr_ctrl) begin
         dyn_freq_switch_en_ff <= pwdata[CTRL_DFS];
         pbr_ff                <= init_ff ? pbr_ff : pwdata[CTRL_PBR];
         init_ff               <= init_ff | pwdata[CTRL_INIT];       // [R5]
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         urgent_lvl_ff <= RST_URGENT;
         normal_lvl_ff <= RST_NORMAL;
         cap_ff        <= RST_CAP;
         bank_lvl_ff   <= RST_BANK;
      end else if (wr_th) begin                                    // [R4]
         urgent_lvl_ff <= fld(pwdata, TH_URG_LSB);
         normal_lvl_ff <= fld(pwdata, TH_NRM_LSB);
         cap_ff        <= fld(pwdata, TH_CAP_LSB);
         bank_lvl_ff   <= fld(pwdata, TH_BNK_LSB);
      end
   end

   // ------------------------------------------------------------
   // frequency switch sequencer
   // ------------------------------------------------------------
   logic              scl_start;
   logic [TMR_W-1:0]  scl_a;
   logic [DIV_W-1:0]  scl_b;
   logic [DIV_W-1:0]  scl_c;
   logic              scl_done;
   logic [TMR_W-1:0]  scl_res;
   logic [TMR_W-1:0]  tmr_remain;
   logic              tick;

   wire in_rem = (sw_ff == SW_SCALE_REM);
   wire in_int = (sw_ff == SW_SCALE_INT);
   wire reload = (sw_ff == SW_WAIT_INT) && scl_done;

   assign scl_start = in_rem || in_int;
   assign scl_a     = in_int ? TMR_W'(TREFI_CYC) : tmr_remain;
   assign scl_b     = in_int ? DIV_W'(1) : div_ff;
   assign scl_c     = target_div_ff;

   always_comb begin
      nxt_sw = sw_ff;
      unique case (sw_ff)
         SW_IDLE:      nxt_sw = switch_go ? SW_REQ : SW_IDLE;
         SW_REQ:       nxt_sw = freq_change_ack ? SW_SCALE_REM : SW_REQ;
         SW_SCALE_REM: nxt_sw = SW_WAIT_REM;
         SW_WAIT_REM:  nxt_sw = scl_done ? SW_SCALE_INT : SW_WAIT_REM;
         SW_SCALE_INT: nxt_sw = SW_WAIT_INT;
         SW_WAIT_INT:  nxt_sw = scl_done ? SW_IDLE : SW_WAIT_INT;
         default:      nxt_sw = SW_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sw_ff         <= SW_IDLE;
         div_ff        <= RST_DIV;
         target_div_ff <= RST_DIV;
         period_ff     <= TMR_W'(TREFI_CYC);
         rem_scaled_ff <= TMR_W'(TREFI_CYC);
      end else begin
         sw_ff <= nxt_sw;
         if (switch_go) begin
            target_div_ff <= req_div;
         end
         // remaining window time, in cycles of the new clock
         if (sw_ff == SW_WAIT_REM && scl_done) begin
            rem_scaled_ff <= scl_res;                               // [R1]
         end
         if (reload) begin
            period_ff <= scl_res;                                   // [R1]
            div_ff    <= target_div_ff;
         end
      end
   end

   assign freq_change_req = (sw_ff == SW_REQ);
   assign freq_div        = target_div_ff;

   ratio_scaler #(
      .AW (TMR_W),
      .BW (DIV_W)
   ) u_scaler (
      .clk    (clk),
      .rst    (rst),
      .start  (scl_start),
      .a      (scl_a),
      .b      (scl_b),
      .c      (scl_c),
      .done   (scl_done),
      .result (scl_res)
   );

   // ------------------------------------------------------------
   // rolling window timer, frozen while the new counts are computed
   // ------------------------------------------------------------
   wire tmr_run = init_ff && (sw_idle || freq_change_req);

   interval_timer #(
      .W (TMR_W)
   ) u_timer (
      .clk      (clk),
      .rst      (rst),
      .run      (tmr_run),
      .load     (reload),                                           // [R1]
      .load_val (rem_scaled_ff),
      .period   (reload ? scl_res : period_ff),
      .tick     (tick),
      .remain   (tmr_remain)
   );

   // ------------------------------------------------------------
   // postponed refresh accounting
   // ------------------------------------------------------------
   wire at_urgent = (postponed_ff >= urgent_lvl_ff);
   wire burst_end = (burst_ff >= cap_ff);
   wire inc       = tick && !ref_done && !at_urgent;                // [R2]
   wire dec       = ref_done && !tick && (postponed_ff != '0);

   always_ff @(posedge clk) begin
      if (rst) begin
         postponed_ff <= '0;
      end else if (inc) begin
         postponed_ff <= postponed_ff + LVL_W'(1);
      end else if (dec) begin
         postponed_ff <= postponed_ff - LVL_W'(1);
      end
   end

   // urgent mode drains refreshes in bursts of at most cap_ff
   always_ff @(posedge clk) begin
      if (rst) begin
         urgent_ff <= 1'b0;
         burst_ff  <= '0;
      end else if (tick) begin
         urgent_ff <= at_urgent;                                    // [R10]
         burst_ff  <= '0;
      end else begin
         if (!urgent_ff && at_urgent) begin
            urgent_ff <= 1'b1;                                      // [R10]
         end else if (urgent_ff && (burst_end || postponed_ff == '0)) begin
            urgent_ff <= 1'b0;                                      // [R10]
         end
         if (urgent_ff && ref_done) begin
            burst_ff <= burst_ff + LVL_W'(1);
         end
      end
   end

   // ------------------------------------------------------------
   // outputs to the scheduler
   // ------------------------------------------------------------
   wire normal_due = (postponed_ff != '0) && (postponed_ff >= normal_lvl_ff);

   assign ref_urgent          = urgent_ff && !burst_end;            // [R10]
   assign ref_req             = init_ff && (ref_urgent || normal_due);  // [R2]
   assign per_bank_refresh_en = pbr_ff;
   assign bank_refresh_more   = pbr_ff && (postponed_ff >= bank_lvl_ff);
   assign ctrl_initialized    = init_ff;

endmodule
`default_nettype wire

// ---- rtl/interval_timer.sv ----
// loadable down counter that marks each refresh interval
`timescale 1ns/1ps
`default_nettype none
module interval_timer
   import refresh_pkg::*;
#(
   parameter int W = TMR_W
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         run,
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   input  wire logic [W-1:0] period,
   output logic              tick,
   output logic [W-1:0]      remain
);
   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;
   wire          at_one = (cnt_ff <= W'(1));

   assign tick    = run && !load && at_one;
   assign remain  = cnt_ff;
   assign nxt_cnt = load ? load_val : (!run ? cnt_ff : (at_one ? period : cnt_ff - W'(1)));

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_ff <= W'(TREFI_CYC);
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/ratio_scaler.sv ----
// sequential a*b/c, used to rescale counts when the clock changes
`timescale 1ns/1ps
`default_nettype none
module ratio_scaler
   import refresh_pkg::*;
#(
   parameter int AW = TMR_W,
   parameter int BW = DIV_W
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          start,
   input  wire logic [AW-1:0] a,
   input  wire logic [BW-1:0] b,
   input  wire logic [BW-1:0] c,
   output logic               done,
   output logic [AW-1:0]      result
);
   localparam int PW = AW + BW;
   logic [PW-1:0]     num_ff;
   logic [PW-1:0]     quo_ff;
   logic [BW:0]       rem_ff;
   logic [BW-1:0]     div_ff;
   logic [5:0]        step_ff;
   logic              busy_ff;
   logic              done_ff;
   logic [AW-1:0]     res_ff;
   wire  [BW+1:0]     trial = {rem_ff, num_ff[PW-1]};
   wire               fits  = trial >= {2'b00, div_ff};
   wire  [BW+1:0]     diff  = trial - {2'b00, div_ff};
   wire               last  = (step_ff == 6'(PW - 1));

   assign done   = done_ff;
   assign result = res_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         res_ff  <= '0;
         num_ff  <= '0;
         quo_ff  <= '0;
         rem_ff  <= '0;
         div_ff  <= '0;
         step_ff <= '0;
      end else begin
         done_ff <= busy_ff && last;
         if (start) begin
            num_ff  <= PW'(a * b);
            div_ff  <= (c == '0) ? BW'(1) : c;
            rem_ff  <= '0;
            quo_ff  <= '0;
            step_ff <= '0;
            busy_ff <= 1'b1;
         end else if (busy_ff) begin
            num_ff  <= {num_ff[PW-2:0], 1'b0};
            rem_ff  <= fits ? diff[BW:0] : trial[BW:0];
            quo_ff  <= {quo_ff[PW-2:0], fits};
            step_ff <= step_ff + 6'd1;
            if (last) begin
               busy_ff <= 1'b0;
               res_ff  <= AW'({quo_ff[PW-2:0], fits});
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- rtl/refresh_pkg.sv ----
// shared constants for the refresh postponement controller
package refresh_pkg;
   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_THRESH = 8'h04;
   localparam logic [7:0] OFS_FREQ   = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   // ------------------------------------------------------------
   // field layout
   // ------------------------------------------------------------
   localparam int LVL_W       = 5;
   localparam int DIV_W       = 4;
   localparam int TMR_W       = 16;
   localparam int CTRL_DFS    = 0;
   localparam int CTRL_PBR    = 1;
   localparam int CTRL_INIT   = 2;
   localparam int TH_URG_LSB  = 0;
   localparam int TH_NRM_LSB  = 8;
   localparam int TH_CAP_LSB  = 16;
   localparam int TH_BNK_LSB  = 24;
   localparam int ST_INIT     = 0;
   localparam int ST_BUSY     = 1;
   localparam int ST_URG      = 2;
   localparam int ST_CNT_LSB  = 8;
   localparam int ST_DIV_LSB  = 16;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [LVL_W-1:0] RST_URGENT = 5'h08;
   localparam logic [LVL_W-1:0] RST_NORMAL = 5'h04;
   localparam logic [LVL_W-1:0] RST_CAP    = 5'h08;
   localparam logic [LVL_W-1:0] RST_BANK   = 5'h02;
   localparam logic [DIV_W-1:0] RST_DIV    = 4'h1;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ   = 250;
   localparam int TREFI_NS  = 3900;
   localparam int TREFI_CYC = (TREFI_NS * CLK_MHZ) / 1000;
   typedef enum logic [2:0] {
      SW_IDLE, SW_REQ, SW_SCALE_REM, SW_WAIT_REM, SW_SCALE_INT, SW_WAIT_INT
   } sw_state_t;
endpackage

// ---- test/refresh_ctrl_assertions.sv ----
// concurrent checks on the ports of the refresh postponement controller
`timescale 1ns/1ps
`default_nettype none
module refresh_ctrl_assertions
   import refresh_pkg::*;
(
   input wire logic             clk,
   input wire logic             rst,
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pwrite,
   input wire logic [7:0]       paddr,
   input wire logic [31:0]      pwdata,
   input wire logic             pready,
   input wire logic             pslverr,
   input wire logic             ref_req,
   input wire logic             ref_urgent,
   input wire logic             per_bank_refresh_en,
   input wire logic             bank_refresh_more,
   input wire logic             freq_change_req,
   input wire logic [DIV_W-1:0] freq_div,
   input wire logic             freq_change_ack,
   input wire logic             ctrl_initialized
);
   // ------------------------------------------------------------
   // access decode
   // ------------------------------------------------------------
   wire logic acc     = psel && penable;
   wire logic wr_freq = acc && pwrite && (paddr == OFS_FREQ);
   wire logic wr_init = acc && pwrite && (paddr == OFS_CTRL) && pwdata[CTRL_INIT];
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   property p_err_map; acc && (paddr[1:0] == 2'h0) |-> pready && (pslverr == (paddr > 8'h0c)); endproperty
   a_err_map: assert property (p_err_map) else $error("slave error does not match address decode");
   property p_err_phase; pslverr |-> acc; endproperty
   a_err_phase: assert property (p_err_phase) else $error("slave error outside access phase");
   property p_req_hold; freq_change_req && !freq_change_ack |=> freq_change_req; endproperty
   a_req_hold: assert property (p_req_hold) else $error("clock switch request dropped before ack");
   property p_req_cause; $rose(freq_change_req) |-> ctrl_initialized && ($past(wr_freq) || $past(wr_freq, 2)); endproperty
   a_req_cause: assert property (p_req_cause) else $error("clock switch request without divisor write");
   property p_div_move; $changed(freq_div) |-> freq_change_req; endproperty
   a_div_move: assert property (p_div_move) else $error("divisor moved outside a switch request");
   property p_ref_init; ref_req |-> ctrl_initialized; endproperty
   a_ref_init: assert property (p_ref_init) else $error("refresh wanted before initialization");
   property p_urg_req; ref_urgent |-> ref_req; endproperty
   a_urg_req: assert property (p_urg_req) else $error("urgent burst without refresh request");
   property p_init_sticky; ctrl_initialized |=> ctrl_initialized; endproperty
   a_init_sticky: assert property (p_init_sticky) else $error("initialized flag fell");
   property p_pbr_frozen; ctrl_initialized && $past(ctrl_initialized) |-> $stable(per_bank_refresh_en); endproperty
   a_pbr_frozen: assert property (p_pbr_frozen) else $error("per-bank mode changed after init");
   property p_bank_more; bank_refresh_more |-> per_bank_refresh_en; endproperty
   a_bank_more: assert property (p_bank_more) else $error("bank continue without per-bank mode");
   property p_init_cause; $rose(ctrl_initialized) |-> $past(wr_init) || $past(wr_init, 2); endproperty
   a_init_cause: assert property (p_init_cause) else $error("initialized without init write");
endmodule
bind dram_refresh_postpone_ctrl refresh_ctrl_assertions refresh_ctrl_assertions_i (
   .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .pslverr(pslverr), .ref_req(ref_req), .ref_urgent(ref_urgent),
   .per_bank_refresh_en(per_bank_refresh_en), .bank_refresh_more(bank_refresh_more),
   .freq_change_req(freq_change_req), .freq_div(freq_div), .freq_change_ack(freq_change_ack),
   .ctrl_initialized(ctrl_initialized));
`default_nettype wire

// ---- test/refresh_partner.sv ----
// memory side model: issues refresh commands and acknowledges clock switches
`timescale 1ns/1ps
`default_nettype none
module refresh_partner #(
   parameter int GAP     = 3,
   parameter int ACK_DLY = 4
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic stall,
   input  wire logic ref_req,
   output logic      ref_done,
   input  wire logic freq_change_req,
   output logic      freq_change_ack
);
   // ------------------------------------------------------------
   // refresh issue, one pulse per command, spaced by GAP
   // ------------------------------------------------------------
   int gap_ff;
   int ack_ff;
   always_ff @(posedge clk) begin
      if (rst) begin
         ref_done        <= 1'b0;
         gap_ff          <= 0;
         freq_change_ack <= 1'b0;
         ack_ff          <= 0;
      end else begin
         ref_done <= ref_req && !stall && (gap_ff == 0) && !ref_done;
         gap_ff   <= (ref_done) ? GAP : ((gap_ff > 0) ? gap_ff - 1 : 0);
         // slow acknowledge of a clock switch
         ack_ff          <= freq_change_req ? ack_ff + 1 : 0;
         freq_change_ack <= freq_change_req && (ack_ff == ACK_DLY) && !freq_change_ack;
      end
   end
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for the refresh postponement controller
`timescale 1ns/1ps
`default_nettype none
module tb;
   import refresh_pkg::*;
   // ------------------------------------------------------------
   // signals and instances
   // ------------------------------------------------------------
   logic             clk = 1'b0;
   logic             rst = 1'b1;
   logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b1;
   logic [7:0]       paddr = 8'h00;
   logic [31:0]      pwdata = 32'h0, prdata, r;
   logic             pready, pslverr, ref_req, ref_urgent, pbr, more, ref_done;
   logic             fc_req, fc_ack, init_done, e, hit;
   logic [DIV_W-1:0] freq_div;
   int               errors = 0, compares = 0, k, n;
   always #2 clk = ~clk;
   dram_refresh_postpone_ctrl dram_refresh_postpone_ctrl_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .ref_req(ref_req), .ref_urgent(ref_urgent), .per_bank_refresh_en(pbr), .bank_refresh_more(more),
      .ref_done(ref_done), .freq_change_req(fc_req), .freq_div(freq_div), .freq_change_ack(fc_ack),
      .ctrl_initialized(init_done));
   refresh_partner refresh_partner_i (.clk(clk), .rst(rst), .stall(stall), .ref_req(ref_req), .ref_done(ref_done),
      .freq_change_req(fc_req), .freq_change_ack(fc_ack));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic rdy;
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // answer is taken from settled values, as seen at the next rising edge
      do begin
         #1;
         rdy = pready;
         r = prdata;
         e = pslverr;
         @(posedge clk);
      end while (rdy !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: pick = ref_urgent;
         1: pick = ref_req;
         2: pick = fc_req;
         default: pick = more;
      endcase
   endfunction
   task automatic wt(input int s, input int lim);
      hit = 1'b0;
      for (int i = 0; i < lim && !hit; i++) begin
         @(posedge clk);
         hit = (pick(s) === 1'b1);
      end
   endtask
   task automatic reset_dut();
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
   endtask
   task automatic finish_test();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (40000) @(posedge clk);
      errors++;
      finish_test();
   end
   initial begin
      reset_dut();
      apb(1, OFS_THRESH, 32'h02081213);
      apb(1, OFS_CTRL, 32'h00000002);
      apb(1, OFS_CTRL, 32'h00000006);
      chk(pbr, 1'b1);
      apb(1, OFS_THRESH, 32'h02081415);
      apb(0, OFS_THRESH, 0);
      chk(r, 32'h02081213);
      apb(1, OFS_FREQ, 32'h00000002);
      wt(2, 6);
      chk(hit, 1'b0);
      wt(3, 3 * TREFI_CYC + 20);
      chk(hit, 1'b1);
      reset_dut();
      apb(0, OFS_CTRL, 0);
      chk(r, 32'h0);
      apb(0, OFS_THRESH, 0);
      chk(r, 32'h02080408);
      apb(0, OFS_STATUS, 0);
      chk(r, 32'h00010000);
      apb(0, 8'h10, 0);
      chk(e, 1'b1);
      apb(1, OFS_THRESH, 32'h02081011);
      apb(1, OFS_CTRL, 32'h00000005);
      apb(1, OFS_THRESH, 32'h0);
      apb(1, OFS_CTRL, 32'h00000007);
      apb(0, OFS_THRESH, 0);
      chk(r, 32'h02081011);
      chk(pbr, 1'b0);
      wt(0, 17 * TREFI_CYC + 100);
      chk(hit, 1'b1);
      repeat (TREFI_CYC + 10) @(posedge clk);
      apb(0, OFS_STATUS, 0);
      chk(r, 32'h00011105);
      stall <= 1'b0;
      n = 0;
      k = 0;
      do begin
         @(posedge clk);
         k++;
         if (ref_done === 1'b1) n++;
      end while (ref_urgent === 1'b1 && k < 300);
      chk(n, 8);
      stall <= 1'b1;
      apb(1, OFS_FREQ, 32'h00000008);
      wt(2, 5);
      chk(hit, 1'b1);
      chk(freq_div, 4'h8);
      for (k = 0; k < 30; k++) begin
         apb(0, OFS_STATUS, 0);
         if (r[ST_BUSY] === 1'b0) break;
      end
      chk(r & 32'h000f0002, 32'h00080000);
      wt(1, 8 * (TREFI_CYC / 8) + 60);
      chk(hit, 1'b1);
      finish_test();
   end
endmodule
`default_nettype wire
